// ==== oew_regs.svh ====
// register offsets, field positions, reset values and timing counts of the oscillator control block
`ifndef OEW_REGS_SVH
`define OEW_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OEW_CTL_OFS        4'h0
`define OEW_SLPCTL_OFS     4'h1
`define OEW_SRC_OFS        4'h2
`define OEW_CORE_CLOCK_OFS       4'h3
`define OEW_STAT_OFS       4'h4
`define OEW_PINFN_OFS      4'h5

// ----------------------------------------
// control word and source register fields
// ----------------------------------------
`define OEW_CTL_INT_ON     0
`define OEW_CTL_FAST_ON    1
`define OEW_CTL_SLOW_ON    2
`define OEW_CTL_EXT_ON     3
`define OEW_CTL_IWT_LSB    4
`define OEW_CTL_FWT_LSB    6
`define OEW_SRC_PICK       2

// ----------------------------------------
// reset values
// ----------------------------------------
`define OEW_CTL_RST        8'h01
`define OEW_SLPCTL_RST     3'h0
`define OEW_SRC_RST        2'h0
`define OEW_PICK_RST       1'h0
`define OEW_GEAR_RST       2'h0
`define OEW_PINFN_RST      3'h0

// ----------------------------------------
// oscillator models: clk_sys cycles per oscillator cycle
// ----------------------------------------
`define OEW_INT_DIV        9'h004
`define OEW_FAST_DIV       9'h002
`define OEW_SLOW_DIV       9'h131

// ----------------------------------------
// stabilization waits in oscillator cycles
// ----------------------------------------
`define OEW_IWT_3          11'h008
`define OEW_IWT_2          11'h010
`define OEW_IWT_1          11'h020
`define OEW_IWT_0          11'h040
`define OEW_FWT_3          11'h080
`define OEW_FWT_2          11'h100
`define OEW_FWT_1          11'h200
`define OEW_FWT_0          11'h400
`define OEW_SWT            11'h100

`endif

// ==== oew_pkg.sv ====
// types shared by the oscillator control block
package oew_pkg;

  typedef enum logic [1:0] {
    OEW_SRC_INT  = 2'h0,
    OEW_SRC_SLOW = 2'h1,
    OEW_SRC_FAST = 2'h2,
    OEW_SRC_RSVD = 2'h3
  } oew_src_e;

  typedef struct packed {
    logic [1:0] fast_osc_wait_sel;
    logic [1:0] int_osc_wait_sel;
    logic       ext_fast_clk_on;
    logic       slow_osc_on;
    logic       fast_osc_on;
    logic       int_osc_on;
  } oew_ctl_s;

  typedef struct packed {
    logic slow_osc_sleep_off;
    logic fast_osc_sleep_off;
    logic int_osc_sleep_off;
  } oew_slp_s;

  typedef struct packed {
    logic out_b_func;
    logic out_a_func;
    logic ext_in_func;
  } oew_pinfn_s;

endpackage

// ==== oew_top.sv ====
// oscillator enable, sleep stop and stabilization wait logic with an avalon-mm register slave
`timescale 1ns/1ps
`include "oew_regs.svh"

module oew_top
  import oew_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sleep_active,
  input  wire logic        ext_fast_clk_pin,
  output logic             int_osc_clk,
  output logic             fast_osc_clk,
  output logic             slow_osc_clk,
  output logic             sys_clk_en,
  output logic             core_clock_en,
  output logic [1:0]       sys_clk_src_sel,
  output logic             ext_in_func,
  output logic             out_a_func,
  output logic             out_b_func
);

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  oew_ctl_s    ctl_reg;
  oew_slp_s    slp_reg;
  oew_src_e    src_reg;
  logic        pick_reg;
  logic [1:0]  gear_reg;
  oew_pinfn_s  pinfn_reg;
  logic        sleep_reg;
  logic        ext_prev_reg;
  logic [2:0]  gear_cnt_reg;
  logic [2:0]  run;
  logic [8:0]  div_max   [3];
  logic [10:0] wait_lim  [3];
  logic [8:0]  div_cnt   [3];
  logic [10:0] wait_cnt  [3];
  logic [2:0]  osc_tick;
  logic [2:0]  wait_rdy;
  logic [2:0]  src_tick;
  logic [2:0]  src_rdy;
  logic [2:0]  osc_clk;
  logic        ext_ok;
  logic        ext_tick;
  logic        wr_ok;
  logic        rd_ok;
  logic        sleep_exit;
  logic        src_wr;
  oew_src_e    src_req;
  logic        src_req_ok;
  logic        sys_tick;
  logic [2:0]  gear_mask;
  logic [31:0] rd_next;
  oew_ctl_s    ctl_next;

  function automatic logic [10:0] oew_int_wait(input logic [1:0] sel);
    case (sel)
      2'h3:    oew_int_wait = `OEW_IWT_3;
      2'h2:    oew_int_wait = `OEW_IWT_2;
      2'h1:    oew_int_wait = `OEW_IWT_1;
      default: oew_int_wait = `OEW_IWT_0;
    endcase
  endfunction

  function automatic logic [10:0] oew_fast_wait(input logic [1:0] sel);
    case (sel)
      2'h3:    oew_fast_wait = `OEW_FWT_3;
      2'h2:    oew_fast_wait = `OEW_FWT_2;
      2'h1:    oew_fast_wait = `OEW_FWT_1;
      default: oew_fast_wait = `OEW_FWT_0;
    endcase
  endfunction

  // ----------------------------------------
  // bus slave: one wait cycle, then answer
  // ----------------------------------------
  assign wr_ok = avs_write && !avs_waitrequest;
  assign rd_ok = avs_read && avs_waitrequest;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      avs_waitrequest <= 1'b1;
    else if (!avs_waitrequest)
      avs_waitrequest <= 1'b1;
    else if (avs_read || avs_write)
      avs_waitrequest <= 1'b0;
  end

  always_comb
  begin
    rd_next = 32'h0;
    if (avs_address == `OEW_CTL_OFS)
      rd_next[7:0] = ctl_reg;
    else if (avs_address == `OEW_SLPCTL_OFS)
      rd_next[2:0] = slp_reg;
    else if (avs_address == `OEW_SRC_OFS)
      rd_next[2:0] = {pick_reg, src_reg};
    else if (avs_address == `OEW_CORE_CLOCK_OFS)
      rd_next[1:0] = gear_reg;
    else if (avs_address == `OEW_STAT_OFS)
      rd_next[5:0] = {run, src_rdy};
    else if (avs_address == `OEW_PINFN_OFS)
      rd_next[2:0] = pinfn_reg;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      avs_readdata <= 32'h0;
    else if (rd_ok)
      avs_readdata <= rd_next;
  end

  // ----------------------------------------
  // sleep tracking
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      sleep_reg <= 1'b0;
    else
      sleep_reg <= sleep_active;
  end

  assign sleep_exit = sleep_reg && !sleep_active;

  // ----------------------------------------
  // oscillator control word
  // ----------------------------------------
  always_comb
  begin
    ctl_next = ctl_reg;
    if (wr_ok && avs_address == `OEW_CTL_OFS)
    begin
      ctl_next = avs_writedata[7:0];
      if (src_reg == OEW_SRC_INT)
        ctl_next.int_osc_on = 1'b1;
      if (src_reg == OEW_SRC_SLOW)
        ctl_next.slow_osc_on = 1'b1;
      if (src_reg == OEW_SRC_FAST && !pick_reg)
        ctl_next.fast_osc_on = 1'b1;
      if (src_reg == OEW_SRC_FAST && pick_reg)
        ctl_next.ext_fast_clk_on = 1'b1;
    end
    if (sleep_exit)
      ctl_next.int_osc_on = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ctl_reg <= `OEW_CTL_RST;
    else
      ctl_reg <= ctl_next;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      slp_reg <= `OEW_SLPCTL_RST;
    else if (wr_ok && avs_address == `OEW_SLPCTL_OFS)
      slp_reg <= avs_writedata[2:0];
  end

  // ----------------------------------------
  // system clock source selection
  // ----------------------------------------
  assign src_wr  = wr_ok && avs_address == `OEW_SRC_OFS;
  assign src_req = oew_src_e'(avs_writedata[1:0]);

  always_comb
  begin
    case (src_req)
      OEW_SRC_INT:  src_req_ok = run[0];
      OEW_SRC_SLOW: src_req_ok = run[2];
      OEW_SRC_FAST: src_req_ok = avs_writedata[`OEW_SRC_PICK] ? ext_ok : run[1];
      default:      src_req_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      src_reg <= oew_src_e'(`OEW_SRC_RST);
    else if (sleep_exit)
      src_reg <= OEW_SRC_INT;
    // switch only to a running source
    else if (src_wr && src_req_ok)
      src_reg <= src_req;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      pick_reg <= `OEW_PICK_RST;
    else if (src_wr && src_reg != OEW_SRC_FAST)
      pick_reg <= avs_writedata[`OEW_SRC_PICK];
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      gear_reg <= `OEW_GEAR_RST;
    else if (wr_ok && avs_address == `OEW_CORE_CLOCK_OFS)
      gear_reg <= avs_writedata[1:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      pinfn_reg <= `OEW_PINFN_RST;
    else if (wr_ok && avs_address == `OEW_PINFN_OFS)
      pinfn_reg <= avs_writedata[2:0];
  end

  // ----------------------------------------
  // oscillator run, wait and gating
  // ----------------------------------------
  // run follows enable and sleep stop
  assign run[0] = ctl_reg.int_osc_on && !(sleep_active && slp_reg.int_osc_sleep_off);
  assign run[1] = ctl_reg.fast_osc_on && !(sleep_active && slp_reg.fast_osc_sleep_off);
  assign run[2] = ctl_reg.slow_osc_on && !(sleep_active && slp_reg.slow_osc_sleep_off);

  assign div_max[0]  = `OEW_INT_DIV;
  assign div_max[1]  = `OEW_FAST_DIV;
  assign div_max[2]  = `OEW_SLOW_DIV;
  assign wait_lim[0] = oew_int_wait(ctl_reg.int_osc_wait_sel);
  assign wait_lim[1] = oew_fast_wait(ctl_reg.fast_osc_wait_sel);
  assign wait_lim[2] = `OEW_SWT;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gen_osc
      always_ff @(posedge clk_sys)
      begin
        if (reset || !run[g])
        begin
          div_cnt[g]  <= 9'h0;
          osc_tick[g] <= 1'b0;
        end
        else if (div_cnt[g] == div_max[g] - 9'h1)
        begin
          div_cnt[g]  <= 9'h0;
          osc_tick[g] <= 1'b1;
        end
        else
        begin
          div_cnt[g]  <= div_cnt[g] + 9'h1;
          osc_tick[g] <= 1'b0;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (reset || !run[g])
        begin
          wait_cnt[g] <= 11'h0;
          wait_rdy[g] <= 1'b0;
        end
        else if (osc_tick[g] && !wait_rdy[g])
        begin
          if (wait_cnt[g] == wait_lim[g] - 11'h1)
            wait_rdy[g] <= 1'b1;
          else
            wait_cnt[g] <= wait_cnt[g] + 11'h1;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (reset || !src_rdy[g])
          osc_clk[g] <= 1'b0;
        else if (src_tick[g])
          osc_clk[g] <= ~osc_clk[g];
      end
    end
  endgenerate

  // ----------------------------------------
  // external fast clock input
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ext_prev_reg <= 1'b0;
    else
      ext_prev_reg <= ext_fast_clk_pin;
  end

  // input accepted only when enabled and routed
  assign ext_ok   = ctl_reg.ext_fast_clk_on && pinfn_reg.ext_in_func;
  assign ext_tick = ext_ok && ext_fast_clk_pin && !ext_prev_reg;

  assign src_tick = {osc_tick[2], pick_reg ? ext_tick : osc_tick[1], osc_tick[0]};
  assign src_rdy  = {wait_rdy[2], pick_reg ? ext_ok : wait_rdy[1], wait_rdy[0]};

  // ----------------------------------------
  // system and core clock enables
  // ----------------------------------------
  // pulses from the selected, stable source only
  assign sys_tick = (src_reg == OEW_SRC_INT)  ? (src_tick[0] && src_rdy[0]) :
                    (src_reg == OEW_SRC_SLOW) ? (src_tick[2] && src_rdy[2]) :
                    (src_reg == OEW_SRC_FAST) ? (src_tick[1] && src_rdy[1]) : 1'b0;

  always_comb
  begin
    case (gear_reg)
      2'h3:    gear_mask = 3'h7;
      2'h2:    gear_mask = 3'h3;
      2'h1:    gear_mask = 3'h1;
      default: gear_mask = 3'h0;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      gear_cnt_reg <= 3'h0;
    else if (sys_tick)
      gear_cnt_reg <= gear_cnt_reg + 3'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sys_clk_en    <= 1'b0;
      core_clock_en <= 1'b0;
    end
    else
    begin
      sys_clk_en    <= sys_tick;
      core_clock_en <= sys_tick && ((gear_cnt_reg & gear_mask) == 3'h0);
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      int_osc_clk     <= 1'b0;
      fast_osc_clk    <= 1'b0;
      slow_osc_clk    <= 1'b0;
      sys_clk_src_sel <= 2'h0;
      ext_in_func     <= 1'b0;
      out_a_func      <= 1'b0;
      out_b_func      <= 1'b0;
    end
    else
    begin
      int_osc_clk     <= osc_clk[0];
      fast_osc_clk    <= osc_clk[1];
      slow_osc_clk    <= osc_clk[2];
      sys_clk_src_sel <= src_reg;
      ext_in_func     <= pinfn_reg.ext_in_func;
      out_a_func      <= pinfn_reg.out_a_func;
      out_b_func      <= pinfn_reg.out_b_func;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_reset_int_on: assert property (@(posedge clk_sys) reset |=> ctl_reg.int_osc_on)
    else $error("internal oscillator not on after reset");
  a_reset_fast_off: assert property (@(posedge clk_sys) reset |=> !ctl_reg.fast_osc_on)
    else $error("fast oscillator not off after reset");
  a_reset_slow_off: assert property (@(posedge clk_sys) reset |=> !ctl_reg.slow_osc_on)
    else $error("slow oscillator not off after reset");
  a_reset_src_int: assert property (@(posedge clk_sys) reset |=> src_reg == OEW_SRC_INT)
    else $error("source not internal after reset");
  a_src_refused: assert property (@(posedge clk_sys) disable iff (reset)
    (src_wr && !src_req_ok && !sleep_exit) |=> $stable(src_reg))
    else $error("switch to a stopped source was taken");
  a_sel_stays_on: assert property (@(posedge clk_sys) disable iff (reset)
    src_reg == OEW_SRC_SLOW |-> ctl_reg.slow_osc_on)
    else $error("selected slow oscillator turned off");
  a_int_wait_hold: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(run[0]) |-> !wait_rdy[0] [*8])
    else $error("internal clock released before its wait");
  a_int_wait_len: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(wait_rdy[0]) |-> $past(wait_cnt[0]) == wait_lim[0] - 11'h1)
    else $error("internal wait length wrong");
  a_sleep_exit: assert property (@(posedge clk_sys) disable iff (reset)
    sleep_exit |=> ctl_reg.int_osc_on && src_reg == OEW_SRC_INT)
    else $error("sleep exit did not restore internal source");
  a_clk_low_wait: assert property (@(posedge clk_sys) disable iff (reset)
    !src_rdy[2] |=> ##1 !slow_osc_clk)
    else $error("slow clock output toggled while waiting");
  a_ext_no_wait: assert property (@(posedge clk_sys) disable iff (reset)
    (pick_reg && ext_tick) |=> osc_clk[1] != $past(osc_clk[1]))
    else $error("external fast clock held by a wait");

endmodule

// ==== oew_testbench.sv ====
// self-checking testbench of the oscillator control block
`timescale 1ns/1ps
`include "oew_regs.svh"

`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
  end

module testbench
  import oew_pkg::*;
;
  typedef struct {
    int         which;
    logic [1:0] sel;
    logic [2:0] src;
    int         cyc;
  } oew_row_s;

  localparam int ID      = `OEW_INT_DIV;
  localparam int FD      = `OEW_FAST_DIV;
  localparam int SD      = `OEW_SLOW_DIV;
  localparam int WDOG    = 95000;

  logic        clk_sys          = 1'h0;
  logic        reset            = 1'h1;
  logic [3:0]  avs_address      = 4'h0;
  logic        avs_read         = 1'h0;
  logic        avs_write        = 1'h0;
  logic [31:0] avs_writedata    = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sleep_active     = 1'h0;
  logic        ext_fast_clk_pin = 1'h0;
  logic        ext_run          = 1'h0;
  logic        int_osc_clk;
  logic        fast_osc_clk;
  logic        slow_osc_clk;
  logic        sys_clk_en;
  logic        core_clock_en;
  logic [1:0]  sys_clk_src_sel;
  logic        ext_in_func;
  logic        out_a_func;
  logic        out_b_func;
  logic [2:0]  oclk;
  logic [7:0]  ctl;
  logic        seen;
  int          error_cnt;
  int          check_count;
  int          n;
  int          ns;
  int          nc;
  int          dv [3]             = '{ID, FD, SD};
  oew_row_s    r;

  // ----------------------------------------
  // wait rows: off then on with a wait select
  // ----------------------------------------
  oew_row_s rows [8] = '{
    '{1, 2'h3, 3'h0, 128 * FD},
    '{1, 2'h2, 3'h0, 256 * FD},
    '{1, 2'h1, 3'h0, 512 * FD},
    '{1, 2'h0, 3'h0, 1024 * FD},
    '{0, 2'h3, 3'h2, 8 * ID},
    '{0, 2'h2, 3'h2, 16 * ID},
    '{0, 2'h1, 3'h2, 32 * ID},
    '{0, 2'h0, 3'h2, 64 * ID}
  };

  assign oclk = {slow_osc_clk, fast_osc_clk, int_osc_clk};

  oew_top uut (
    .clk_sys          (clk_sys),
    .reset            (reset),
    .avs_address      (avs_address),
    .avs_read         (avs_read),
    .avs_write        (avs_write),
    .avs_writedata    (avs_writedata),
    .avs_readdata     (avs_readdata),
    .avs_waitrequest  (avs_waitrequest),
    .sleep_active     (sleep_active),
    .ext_fast_clk_pin (ext_fast_clk_pin),
    .int_osc_clk      (int_osc_clk),
    .fast_osc_clk     (fast_osc_clk),
    .slow_osc_clk     (slow_osc_clk),
    .sys_clk_en       (sys_clk_en),
    .core_clock_en    (core_clock_en),
    .sys_clk_src_sel  (sys_clk_src_sel),
    .ext_in_func      (ext_in_func),
    .out_a_func       (out_a_func),
    .out_b_func       (out_b_func)
  );

  always #50 clk_sys = !clk_sys;

  // external source toggles only once told to; it is stable from the start
  // stable outside clock
  always @(posedge clk_sys)
  begin
    if (ext_run)
      ext_fast_clk_pin <= !ext_fast_clk_pin;
  end

  // ----------------------------------------
  // bus and check helpers
  // ----------------------------------------
  task automatic bus(input logic wr_en, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr_en;
    avs_read <= !wr_en;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (avs_waitrequest !== 1'h0 && k < 40);
    rd = avs_readdata;
    if (k >= 40)
    begin
      error_cnt++;
      $display("Error bus answer missing");
    end
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [3:0] adr, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'h1, adr, wd, d);
  endtask

  task automatic rdchk(input string nm, input logic [3:0] adr, input logic [31:0] e);
    logic [31:0] d;
    bus(1'h0, adr, 32'h0, d);
    `CHK(nm, e, d)
  endtask

  // cycles until an oscillator output first goes high
  task automatic rise(input int w, output int k);
    k = 0;
    while (oclk[w] !== 1'h1 && k < 90000)
    begin
      @(posedge clk_sys);
      k++;
    end
  endtask

  task automatic win(input string nm, input int k, input int e, input int d);
    `CHK(nm, 1'h1, (k >= e - d - 2) && (k <= e + 2 * d + 8))
  endtask

  task automatic reset_vals();
    rdchk("ctl rst", `OEW_CTL_OFS, 32'h01);
    rdchk("slp rst", `OEW_SLPCTL_OFS, 32'h0);
    rdchk("src rst", `OEW_SRC_OFS, 32'h0);
    rdchk("gear rst", `OEW_CORE_CLOCK_OFS, 32'h0);
    rdchk("pin rst", `OEW_PINFN_OFS, 32'h0);
    `CHK("pins", 3'h0, {ext_in_func, out_a_func, out_b_func})
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (WDOG) @(posedge clk_sys);
    error_cnt++;
    $display("Error watchdog expired");
    tally_and_finish();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    error_cnt = 0;
    check_count = 0;
    ctl = 8'h01;
    repeat (4) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    foreach (rows[i])
    begin
      r = rows[i];
      wr(`OEW_SRC_OFS, 32'(r.src));
      ctl[r.which] = 1'h0;
      wr(`OEW_CTL_OFS, 32'(ctl));
      repeat (dv[r.which] + 2) @(posedge clk_sys);
      `CHK("osc off", 1'h0, oclk[r.which])
      if (r.which == 0)
        ctl[5:4] = r.sel;
      else
        ctl[7:6] = r.sel;
      ctl[r.which] = 1'h1;
      wr(`OEW_CTL_OFS, 32'(ctl));
      rise(r.which, n);
      win("osc wait", n, r.cyc, dv[r.which]);
    end
    `CHK("src sel", OEW_SRC_FAST, sys_clk_src_sel)
    for (int g = 0; g < 4; g++)
    begin
      wr(`OEW_CORE_CLOCK_OFS, 32'(g));
      ns = 0;
      nc = 0;
      while (ns < 64)
      begin
        @(posedge clk_sys);
        ns += int'(sys_clk_en);
        nc += int'(core_clock_en);
      end
      `CHK("gear", 64 >> g, nc)
    end
    // selected source refuses to stop, idle source refuses selection
    wr(`OEW_CTL_OFS, 32'h01);
    rdchk("keep sel", `OEW_CTL_OFS, 32'h03);
    wr(`OEW_SRC_OFS, 32'h1);
    rdchk("src idle", `OEW_SRC_OFS, 32'h2);
    wr(`OEW_SRC_OFS, 32'h3);
    rdchk("src rsvd", `OEW_SRC_OFS, 32'h2);
    `CHK("src pin", OEW_SRC_FAST, sys_clk_src_sel)
    // sleep with fast stop bit, internal off beforehand
    wr(`OEW_SLPCTL_OFS, 32'h2);
    wr(`OEW_CTL_OFS, 32'h02);
    rdchk("int off", `OEW_CTL_OFS, 32'h02);
    sleep_active <= 1'h1;
    repeat (FD + 4) @(posedge clk_sys);
    seen = 1'h0;
    repeat (32)
    begin
      @(posedge clk_sys);
      seen |= fast_osc_clk;
    end
    `CHK("sleep stop", 1'h0, seen)
    sleep_active <= 1'h0;
    repeat (3) @(posedge clk_sys);
    rdchk("wake ctl", `OEW_CTL_OFS, 32'h03);
    rdchk("wake src", `OEW_SRC_OFS, 32'h0);
    `CHK("wake sel", OEW_SRC_INT, sys_clk_src_sel)
    // slow crystal start and selection
    wr(`OEW_CTL_OFS, 32'h07);
    // all three run, none has finished its wait yet
    rdchk("stat wait", `OEW_STAT_OFS, 32'h38);
    rise(2, n);
    win("slow wait", n, 256 * SD, SD);
    wr(`OEW_SRC_OFS, 32'h1);
    rdchk("src slow", `OEW_SRC_OFS, 32'h1);
    rdchk("stat rdy", `OEW_STAT_OFS, 32'h3f);
    wr(`OEW_SRC_OFS, 32'h0);
    // external input: ignored while disabled, no wait once enabled
    wr(`OEW_PINFN_OFS, 32'h7);
    // pin selects reach the outputs one cycle after the register
    @(posedge clk_sys);
    `CHK("pin func", 3'h7, {ext_in_func, out_a_func, out_b_func})
    wr(`OEW_CTL_OFS, 32'h01);
    wr(`OEW_SRC_OFS, 32'h4);
    wr(`OEW_CTL_OFS, 32'h03);
    ext_run <= 1'h1;
    seen = 1'h0;
    repeat (40)
    begin
      @(posedge clk_sys);
      seen |= fast_osc_clk;
    end
    `CHK("ext off", 1'h0, seen)
    wr(`OEW_CTL_OFS, 32'h0b);
    rise(1, n);
    `CHK("ext nowait", 1'h1, n < 16)
    // second reset in mid-run, then unmapped access
    reset <= 1'h1;
    repeat (4) @(posedge clk_sys);
    reset <= 1'h0;
    ext_run <= 1'h0;
    @(posedge clk_sys);
    rise(0, n);
    win("int rst", n, 64 * ID, ID);
    `CHK("rst sel", OEW_SRC_INT, sys_clk_src_sel)
    reset_vals();
    wr(4'hf, 32'hff);
    rdchk("unmapped", 4'hf, 32'h0);
    tally_and_finish();
  end
endmodule
